/* inc/fsr_defines.vh */
`ifndef FSR_DEFINES_VH
`define FSR_DEFINES_VH

// Clock and timing, in nanoseconds
`define FSR_MCLK_NS 25
`define FSR_SUSP_LAT_NS 30000
`define FSR_OTP_PGM_NS 2000000

// Command codes
`define FSR_CMD_SUSPEND 8'h75
`define FSR_CMD_RESUME 8'h7a
`define FSR_CMD_OTP_RD 8'h4b
`define FSR_CMD_OTP_PGM 8'h42

// Flag status layout and power-up value
`define FSR_FLAG_RST 8'h80
`define FSR_B_READY 7
`define FSR_B_ERS_SUSP 6
`define FSR_B_PGM_ERR 4
`define FSR_B_PGM_SUSP 2
`define FSR_B_PROT 1

// OTP area
`define FSR_OTP_LAST 7'h40
`define FSR_OTP_NBYTES 7'h41
`define FSR_OTP_ERASED 8'hff
`define FSR_LOCK_BIT 0

// Serial framing
`define FSR_ADDR_BITS 5'h18
`define FSR_DUMMY_CYC 5'h08

// Array geometry, as address bit positions
`define FSR_PAGE_LSB 8
`define FSR_SECT_LSB 16

`endif

/* logic/fsr_sync.v */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser for a vector of independent levels
module fsr_sync #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire clk,
    input wire arst_n,
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);

reg [WIDTH-1:0] meta_r;

// First stage feeds only the second stage
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        meta_r <= RST_VAL;
        q <= RST_VAL;
    end else begin
        meta_r <= d;
        q <= meta_r;
    end
end

endmodule // fsr_sync

/* logic/fsr_ctrl.v */
`timescale 1ns/1ps
`include "fsr_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module fsr_ctrl #(
    parameter ADDR_W = 25,
    parameter CNT_W = 17,
    parameter SUSP_LAT_CYC = `FSR_SUSP_LAT_NS / `FSR_MCLK_NS,
    parameter OTP_PGM_CYC = (`FSR_OTP_PGM_NS + `FSR_MCLK_NS - 1) / `FSR_MCLK_NS
) (
    input wire MCLK,
    input wire ARST_N,
    input wire CS_N,
    input wire SCLK,
    input wire SDI,
    input wire WEL,
    input wire OP_RUN,
    input wire OP_ERASE,
    input wire OP_NEAR_DONE,
    input wire [ADDR_W-1:0] OP_ADDR,
    input wire LOCK_IN,
    input wire [ADDR_W-1:0] RD_ADDR,
    input wire PGM_REQ,
    input wire [ADDR_W-1:0] PGM_ADDR,
    input wire CLR_ERR,
    output reg SDO,
    output reg SDO_OE,
    output reg [7:0] FLAG_STATUS,
    output reg WIP,
    output reg HALT_PGM,
    output reg HALT_ERS,
    output reg ERS_LOCK,
    output reg RD_UNDEF,
    output reg PGM_DISCARD,
    output reg WEL_CLR
);

// Cycle counts are worked out wide, then cut to the counter width on purpose
localparam integer LAT_CYC_LAST = SUSP_LAT_CYC - 1;
localparam integer OTP_CYC_LAST = OTP_PGM_CYC - 1;
localparam [CNT_W-1:0] LAT_END = LAT_CYC_LAST[CNT_W-1:0];
localparam [CNT_W-1:0] OTP_END = OTP_CYC_LAST[CNT_W-1:0];
localparam [5:0] ST_CMD = 6'h01;
localparam [5:0] ST_ADDR = 6'h02;
localparam [5:0] ST_DUMMY = 6'h04;
localparam [5:0] ST_RDATA = 6'h08;
localparam [5:0] ST_PDATA = 6'h10;
localparam [5:0] ST_IGN = 6'h20;

// Clamp an address to the OTP range; beyond the control byte reads stick there
function [6:0] otp_idx;
    input [23:0] a;
    begin
        otp_idx = (a > {17'h00000, `FSR_OTP_LAST}) ? `FSR_OTP_LAST : a[6:0];
    end
endfunction

// Same sector test, used for both reads and programs
function sect_eq;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] b;
    begin
        sect_eq = (a[ADDR_W-1:`FSR_SECT_LSB] == b[ADDR_W-1:`FSR_SECT_LSB]);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin sampling

wire [2:0] pin_s;
wire cs_n_s = pin_s[2];
wire sck_s = pin_s[1];
wire sdi_s = pin_s[0];
reg sck_d_r;
reg cs_d_r;

fsr_sync #(.WIDTH(3), .RST_VAL(3'h4)) u_sync (
    .clk(MCLK),
    .arst_n(ARST_N),
    .d({CS_N, SCLK, SDI}),
    .q(pin_s)
);

// Edge history of the sampled serial clock and select
always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
        sck_d_r <= 1'b0;
        cs_d_r <= 1'b1;
    end else begin
        sck_d_r <= sck_s;
        cs_d_r <= cs_n_s;
    end
end

wire sck_rise = sck_s & ~sck_d_r & ~cs_n_s;
wire sck_fall = ~sck_s & sck_d_r & ~cs_n_s;
wire cs_rise = cs_n_s & ~cs_d_r;

////////////////////////////////////////////////////////////////////////////////
// Serial command engine

reg [5:0] st_r;
reg [4:0] cnt_r;
reg [2:0] bit_r;
reg [7:0] sh_r;
reg [7:0] cmd_r;
reg [23:0] adr_r;
reg extra_r;
reg [7:0] osh_r;
reg [6:0] ridx_r;
reg [6:0] wptr_r;
reg [6:0] nbyte_r;
reg [64:0] pmask_r;
reg otp_busy_r;
reg [7:0] otp_mem [0:64];
reg [7:0] pbuf [0:64];

wire [7:0] byte_in = {sh_r[6:0], sdi_s};
wire [23:0] adr_in = {adr_r[22:0], sdi_s};
wire [6:0] ridx_nxt = (ridx_r == `FSR_OTP_LAST) ? ridx_r : ridx_r + 7'h01;
wire byte_done = sck_rise & (bit_r == 3'h7);
// Bytes past the control byte or past 65 are dropped, never wrapped
wire pb_we = byte_done & (st_r == ST_PDATA) & (wptr_r <= `FSR_OTP_LAST)
    & (nbyte_r != `FSR_OTP_NBYTES);

// Holding buffer carries no reset; the byte mask says what is valid
always @(posedge MCLK) begin
    if (pb_we) begin
        pbuf[wptr_r] <= byte_in;
    end
end

// Command, address, dummy and data phases; select high restarts the frame
always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
        st_r <= ST_CMD;
        cnt_r <= 5'h00;
        bit_r <= 3'h0;
        sh_r <= 8'h00;
        cmd_r <= 8'h00;
        adr_r <= 24'h000000;
        extra_r <= 1'b0;
        osh_r <= 8'h00;
        ridx_r <= 7'h00;
        wptr_r <= 7'h00;
        nbyte_r <= 7'h00;
        pmask_r <= 65'h0;
        SDO <= 1'b0;
        SDO_OE <= 1'b0;
    end else if (cs_n_s) begin
        st_r <= ST_CMD;
        cnt_r <= 5'h00;
        bit_r <= 3'h0;
        SDO_OE <= 1'b0;
    end else begin
        if (sck_rise) begin
            sh_r <= byte_in;
            bit_r <= bit_r + 3'h1;
            case (st_r)
                ST_CMD: begin
                    if (bit_r == 3'h7) begin
                        cmd_r <= byte_in;
                        extra_r <= 1'b0;
                        cnt_r <= 5'h00;
                        if (byte_in == `FSR_CMD_OTP_RD) begin
                            st_r <= ST_ADDR;
                        end else if (byte_in == `FSR_CMD_OTP_PGM && !otp_busy_r) begin
                            st_r <= ST_ADDR;
                        end else begin
                            st_r <= ST_IGN;
                        end
                    end
                end
                ST_ADDR: begin
                    adr_r <= adr_in;
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == `FSR_ADDR_BITS - 5'h01) begin
                        cnt_r <= 5'h00;
                        if (cmd_r == `FSR_CMD_OTP_RD) begin
                            st_r <= ST_DUMMY;
                        end else begin
                            st_r <= ST_PDATA;
                            wptr_r <= otp_idx(adr_in);
                            nbyte_r <= 7'h00;
                            pmask_r <= 65'h0;
                        end
                    end
                end
                ST_DUMMY: begin
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == `FSR_DUMMY_CYC - 5'h01) begin
                        cnt_r <= 5'h00;
                        st_r <= ST_RDATA;
                        ridx_r <= otp_idx(adr_r);
                        osh_r <= otp_mem[otp_idx(adr_r)];
                    end
                end
                ST_PDATA: begin
                    if (bit_r == 3'h7) begin
                        if (pb_we) begin
                            pmask_r[wptr_r] <= 1'b1;
                        end
                        if (nbyte_r != `FSR_OTP_NBYTES) begin
                            nbyte_r <= nbyte_r + 7'h01;
                        end
                        if (wptr_r != `FSR_OTP_NBYTES) begin
                            wptr_r <= wptr_r + 7'h01;
                        end
                    end
                end
                ST_IGN: begin
                    extra_r <= 1'b1;
                end
                default: begin
                    st_r <= st_r;
                end
            endcase
        end
        // Data leaves on falling edges so the host samples it just before the next fall
        if (sck_fall && st_r == ST_RDATA) begin
            SDO <= osh_r[7];
            SDO_OE <= 1'b1;
            osh_r <= {osh_r[6:0], 1'b0};
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r[2:0] == 3'h7) begin
                ridx_r <= ridx_nxt;
                osh_r <= otp_mem[ridx_nxt];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Command execution at select rise; single-byte commands need exactly 8 clocks

wire exec_susp = cs_rise & (st_r == ST_IGN) & ~extra_r & (cmd_r == `FSR_CMD_SUSPEND);
wire exec_res = cs_rise & (st_r == ST_IGN) & ~extra_r & (cmd_r == `FSR_CMD_RESUME);
wire exec_pgm = cs_rise & (st_r == ST_PDATA) & (bit_r == 3'h0) & (nbyte_r != 7'h00)
    & WEL & ~otp_busy_r;
wire otp_locked = ~otp_mem[`FSR_OTP_LAST][`FSR_LOCK_BIT];

reg [CNT_W-1:0] otp_tmr_r;
reg prot_set_r;
integer i;

// OTP array; programming only clears bits, so a lock can never undo itself
always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
        for (i = 0; i < 65; i = i + 1) begin
            otp_mem[i] <= `FSR_OTP_ERASED;
        end
        otp_busy_r <= 1'b0;
        otp_tmr_r <= {CNT_W{1'b0}};
        prot_set_r <= 1'b0;
        WEL_CLR <= 1'b0;
    end else begin
        prot_set_r <= exec_pgm & otp_locked;
        WEL_CLR <= 1'b0;
        if (exec_pgm && !otp_locked) begin
            otp_busy_r <= 1'b1;
            otp_tmr_r <= {CNT_W{1'b0}};
        end else if (otp_busy_r) begin
            otp_tmr_r <= otp_tmr_r + 1'b1;
            if (otp_tmr_r == OTP_END) begin
                otp_busy_r <= 1'b0;
                WEL_CLR <= 1'b1;
                for (i = 0; i < 65; i = i + 1) begin
                    if (pmask_r[i]) begin
                        otp_mem[i] <= otp_mem[i] & pbuf[i];
                    end
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Suspend and resume

reg pgm_flag_r;
reg ers_flag_r;
reg susp_pend_r;
reg res_pend_r;
reg near_r;
reg near_ers_r;
reg [CNT_W-1:0] lat_r;
reg [ADDR_W-1:0] pgm_at_r;
reg [ADDR_W-1:0] ers_at_r;
reg perr_r;
reg prot_r;
reg [7:0] flag_nxt;

wire busy = OP_RUN | susp_pend_r | res_pend_r | otp_busy_r;
// Only an idle slot of the right kind may be suspended; one nesting level
wire susp_ok = exec_susp & OP_RUN & ~susp_pend_r & ~res_pend_r & ~near_r
    & (OP_ERASE ? ~ers_flag_r & ~pgm_flag_r : ~pgm_flag_r);
wire res_ok = exec_res & ~susp_pend_r & ~OP_RUN & (HALT_PGM | HALT_ERS);
wire discard = PGM_REQ & HALT_ERS & sect_eq(PGM_ADDR, ers_at_r);

// Halt requests, suspend flags and latency timing
always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
        pgm_flag_r <= 1'b0;
        ers_flag_r <= 1'b0;
        HALT_PGM <= 1'b0;
        HALT_ERS <= 1'b0;
        susp_pend_r <= 1'b0;
        res_pend_r <= 1'b0;
        near_r <= 1'b0;
        near_ers_r <= 1'b0;
        lat_r <= {CNT_W{1'b0}};
        pgm_at_r <= {ADDR_W{1'b0}};
        ers_at_r <= {ADDR_W{1'b0}};
        ERS_LOCK <= 1'b0;
    end else begin
        if (susp_ok) begin
            if (OP_ERASE) begin
                ers_flag_r <= 1'b1;
            end else begin
                pgm_flag_r <= 1'b1;
            end
            if (OP_NEAR_DONE) begin
                near_r <= 1'b1;
                near_ers_r <= OP_ERASE;
            end else begin
                susp_pend_r <= 1'b1;
                lat_r <= {CNT_W{1'b0}};
                if (OP_ERASE) begin
                    HALT_ERS <= 1'b1;
                    ers_at_r <= OP_ADDR;
                    ERS_LOCK <= LOCK_IN;
                end else begin
                    HALT_PGM <= 1'b1;
                    pgm_at_r <= OP_ADDR;
                end
            end
        end
        // Ready rises only once the whole latency has run out
        if (susp_pend_r) begin
            lat_r <= lat_r + 1'b1;
            if (lat_r == LAT_END) begin
                susp_pend_r <= 1'b0;
            end
        end
        // A short remainder runs to completion, then its suspend bit clears
        if (near_r && !OP_RUN) begin
            near_r <= 1'b0;
            if (near_ers_r) begin
                ers_flag_r <= 1'b0;
            end else begin
                pgm_flag_r <= 1'b0;
            end
        end
        // Inner program resumes first, the outer erase on the next resume
        if (res_ok) begin
            res_pend_r <= 1'b1;
            if (HALT_PGM) begin
                HALT_PGM <= 1'b0;
                pgm_flag_r <= 1'b0;
            end else begin
                HALT_ERS <= 1'b0;
                ers_flag_r <= 1'b0;
            end
        end else if (res_pend_r && OP_RUN) begin
            res_pend_r <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Flag status, progress and access screening

// Flag byte is assembled here and registered below
always @* begin
    flag_nxt = 8'h00;
    flag_nxt[`FSR_B_READY] = ~busy;
    flag_nxt[`FSR_B_ERS_SUSP] = ers_flag_r;
    flag_nxt[`FSR_B_PGM_ERR] = perr_r;
    flag_nxt[`FSR_B_PGM_SUSP] = pgm_flag_r;
    flag_nxt[`FSR_B_PROT] = prot_r;
end

// Error bits: a new error in the clearing cycle is kept
always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
        perr_r <= 1'b0;
        prot_r <= 1'b0;
        FLAG_STATUS <= `FSR_FLAG_RST;
        WIP <= 1'b0;
        RD_UNDEF <= 1'b0;
        PGM_DISCARD <= 1'b0;
    end else begin
        if (discard || prot_set_r) begin
            perr_r <= 1'b1;
        end else if (CLR_ERR) begin
            perr_r <= 1'b0;
        end
        if (prot_set_r) begin
            prot_r <= 1'b1;
        end else if (CLR_ERR) begin
            prot_r <= 1'b0;
        end
        FLAG_STATUS <= flag_nxt;
        WIP <= busy;
        // Write enable latch is left alone on a discarded program
        PGM_DISCARD <= discard;
        RD_UNDEF <= (HALT_PGM & (RD_ADDR[ADDR_W-1:`FSR_PAGE_LSB]
            == pgm_at_r[ADDR_W-1:`FSR_PAGE_LSB]))
            | (HALT_ERS & sect_eq(RD_ADDR, ers_at_r));
    end
end

endmodule // fsr_ctrl

/* testbench/fsr_ctrl_properties.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Port-level checks on the suspend and OTP sequencer
module fsr_ctrl_checker (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic CS_N,
    input wire logic OP_RUN,
    input wire logic PGM_REQ,
    input wire logic SDO_OE,
    input wire logic [7:0] FLAG_STATUS,
    input wire logic WIP,
    input wire logic HALT_PGM,
    input wire logic HALT_ERS,
    input wire logic ERS_LOCK,
    input wire logic RD_UNDEF,
    input wire logic PGM_DISCARD,
    input wire logic WEL_CLR
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!ARST_N);

    ////////////////////////////////////////////////////////////////////////////
    // Suspend flags and readiness
    a_reset_flag: assert property ($rose(ARST_N) |-> FLAG_STATUS == 8'h80)
        else $error("flag byte wrong after reset");
    a_erase_flag: assert property ($rose(HALT_ERS) |-> ##[0:1] FLAG_STATUS[6])
        else $error("erase suspend flag missing");
    a_prog_flag: assert property ($rose(HALT_PGM) |-> ##[0:1] FLAG_STATUS[2])
        else $error("program suspend flag missing");
    // Two cycles of running covers either register depth of the ready path
    a_run_busy: assert property (OP_RUN ##1 OP_RUN |=> !FLAG_STATUS[7])
        else $error("ready while operation runs");
    a_resume_busy: assert property ($fell(HALT_PGM) || $fell(HALT_ERS)
        |-> ##[0:2] (WIP && !FLAG_STATUS[7]))
        else $error("resume did not show busy");
    a_nest_order: assert property ($fell(HALT_ERS) |-> !HALT_PGM)
        else $error("erase resumed before program");
    a_lock_held: assert property (HALT_ERS && $past(HALT_ERS) |-> $stable(ERS_LOCK))
        else $error("captured lock changed while suspended");
    a_undef_idle: assert property ((!HALT_PGM && !HALT_ERS) [*3] |-> !RD_UNDEF)
        else $error("read screened with nothing suspended");
    a_discard_err: assert property (PGM_DISCARD
        |-> ($past(PGM_REQ) && HALT_ERS) ##[0:1] FLAG_STATUS[4])
        else $error("discard without cause or error flag");

    ////////////////////////////////////////////////////////////////////////////
    // Serial output and OTP program
    a_out_release: assert property ($rose(CS_N) |-> ##[1:5] !SDO_OE)
        else $error("output still driven after deselect");
    a_otp_busy: assert property (WEL_CLR |-> $past(WIP))
        else $error("program ended without busy");

    c_erase_susp: cover property ($rose(HALT_ERS));
    c_nested: cover property ($rose(HALT_PGM) && HALT_ERS);
    c_otp_done: cover property (WEL_CLR);
    c_discard: cover property (PGM_DISCARD);
endmodule // fsr_ctrl_checker

bind fsr_ctrl fsr_ctrl_checker chk_u (
    .MCLK(MCLK), .ARST_N(ARST_N), .CS_N(CS_N), .OP_RUN(OP_RUN), .PGM_REQ(PGM_REQ),
    .SDO_OE(SDO_OE), .FLAG_STATUS(FLAG_STATUS), .WIP(WIP), .HALT_PGM(HALT_PGM),
    .HALT_ERS(HALT_ERS), .ERS_LOCK(ERS_LOCK), .RD_UNDEF(RD_UNDEF),
    .PGM_DISCARD(PGM_DISCARD), .WEL_CLR(WEL_CLR)
);

/* testbench/fsr_host_model.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Host on the serial link; its clock rests low between frames
module fsr_host_model (
    input wire logic MCLK,
    output logic CS_N,
    output logic SCLK,
    output logic SDI,
    input wire logic SDO,
    input wire logic SDO_OE
);
    logic [7:0] rx_q[$];

    initial begin
        CS_N = 1'b1;
        SCLK = 1'b0;
        SDI = 1'b0;
    end

    // Idle data line toggles so a stale bit can never look valid
    always @(posedge MCLK) begin
        if (CS_N) SDI <= ~SDI;
    end

    // Half a link period is four system cycles (200 ns link clock)
    task automatic half();
        repeat (4) @(posedge MCLK);
        #2;
    endtask

    // Whole bytes out MSB first on rises, then nrd bytes in just before each fall
    task automatic frame(input logic [7:0] tx[$], input int nrd);
        logic [7:0] v;
        rx_q.delete();
        CS_N = 1'b0;
        foreach (tx[i]) begin
            for (int b = 7; b >= 0; b--) begin
                SDI = tx[i][b];
                half();
                SCLK = 1'b1;
                half();
                SCLK = 1'b0;
            end
        end
        for (int k = 0; k < nrd * 8; k++) begin
            half();
            SCLK = 1'b1;
            half();
            v = {v[6:0], SDO_OE ? SDO : 1'bx};
            SCLK = 1'b0;
            if (k % 8 == 7) rx_q.push_back(v);
        end
        half();
        CS_N = 1'b1;
        half();
        half();
    endtask
endmodule // fsr_host_model

/* testbench/flash_suspend_resume_otp_ctrl_test.sv */
`timescale 1ns/1ps
`include "fsr_defines.vh"

module flash_suspend_resume_otp_ctrl_test;
    localparam int LAT = 40;
    localparam int PGM = 20;
    logic MCLK = 1'b0, ARST_N = 1'b0, WEL = 1'b0, OP_RUN = 1'b0, OP_ERASE = 1'b0;
    logic OP_NEAR_DONE = 1'b0, LOCK_IN = 1'b0, PGM_REQ = 1'b0, CLR_ERR = 1'b0;
    logic [24:0] OP_ADDR = '0, RD_ADDR = '0, PGM_ADDR = '0;
    wire CS_N, SCLK, SDI, SDO, SDO_OE, WIP, HALT_PGM, HALT_ERS, ERS_LOCK;
    wire RD_UNDEF, PGM_DISCARD, WEL_CLR;
    wire [7:0] FLAG_STATUS;
    int bad_count = 0, checked = 0, cyc = 0;
    logic [7:0] d[$];
    logic [7:0] otp_m[0:64];

    always #12.5 MCLK = ~MCLK;

    fsr_ctrl #(.SUSP_LAT_CYC(LAT), .OTP_PGM_CYC(PGM)) dut_u (
        .MCLK(MCLK), .ARST_N(ARST_N), .CS_N(CS_N), .SCLK(SCLK), .SDI(SDI), .WEL(WEL),
        .OP_RUN(OP_RUN), .OP_ERASE(OP_ERASE), .OP_NEAR_DONE(OP_NEAR_DONE),
        .OP_ADDR(OP_ADDR), .LOCK_IN(LOCK_IN), .RD_ADDR(RD_ADDR), .PGM_REQ(PGM_REQ),
        .PGM_ADDR(PGM_ADDR), .CLR_ERR(CLR_ERR), .SDO(SDO), .SDO_OE(SDO_OE),
        .FLAG_STATUS(FLAG_STATUS), .WIP(WIP), .HALT_PGM(HALT_PGM), .HALT_ERS(HALT_ERS),
        .ERS_LOCK(ERS_LOCK), .RD_UNDEF(RD_UNDEF), .PGM_DISCARD(PGM_DISCARD),
        .WEL_CLR(WEL_CLR)
    );
    fsr_host_model h_u (.MCLK(MCLK), .CS_N(CS_N), .SCLK(SCLK), .SDI(SDI), .SDO(SDO),
        .SDO_OE(SDO_OE));

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge MCLK);
        #2;
    endtask

    // Address stops at the control byte instead of wrapping
    function automatic logic [7:0] exp_byte(input int a);
        return otp_m[(a > 64) ? 64 : a];
    endfunction

    task automatic cmd(input logic [7:0] c, input logic [23:0] a, input int na, input int nrd);
        logic [7:0] q[$];
        q = {c};
        for (int i = 0; i < na; i++) q.push_back(a[23 - 8 * i -: 8]);
        q = {q, d};
        d.delete();
        h_u.frame(q, nrd);
        tick(2);
    endtask

    task automatic otp_rd(input logic [23:0] a, input int n);
        d = {8'h00};
        cmd(`FSR_CMD_OTP_RD, a, 3, n);
        for (int i = 0; i < n; i++) chk("otp_rd", exp_byte(a + i), h_u.rx_q[i]);
        chk("sdo_oe", 0, SDO_OE);
    endtask

    // Array model ANDs data in, drops bytes past the control byte
    task automatic otp_pgm(input logic [23:0] a);
        int k;
        bit ok;
        ok = otp_m[64][0];
        foreach (d[i]) if (ok && i < 65 && a + i <= 64) otp_m[a + i] = otp_m[a + i] & d[i];
        WEL = 1'b1;
        cmd(`FSR_CMD_OTP_PGM, a, 3, 0);
        if (ok) begin
            chk("wip", 1, WIP);
            k = 0;
            while (WEL_CLR !== 1'b1 && k < PGM + 20) begin
                tick(1);
                k++;
            end
            chk("wel_clr", 1, WEL_CLR);
            tick(2);
            chk("wip", 0, WIP);
        end else begin
            chk("flag", 8'h92, FLAG_STATUS);
            chk("wip", 0, WIP);
        end
        WEL = 1'b0;
    endtask

    task automatic pulse_clr();
        CLR_ERR = 1'b1;
        tick(1);
        CLR_ERR = 1'b0;
        tick(2);
    endtask

    task automatic scr(input logic [24:0] a, input logic e);
        RD_ADDR = a;
        tick(2);
        chk("rd_undef", e, RD_UNDEF);
    endtask

    task automatic preq(input logic [24:0] a, input logic e);
        PGM_ADDR = a;
        PGM_REQ = 1'b1;
        tick(1);
        chk("discard", e, PGM_DISCARD);
        PGM_REQ = 1'b0;
        tick(2);
    endtask

    // Core side: resumed work runs a while, then finishes
    task automatic run_op(input logic er);
        OP_ERASE = er;
        OP_RUN = 1'b1;
        tick(5);
        chk("ready", 0, FLAG_STATUS[7]);
        OP_RUN = 1'b0;
        tick(4);
        chk("wip_ready", 2'b01, {WIP, FLAG_STATUS[7]});
    endtask

    // A hang counts as a mismatch and closes the run
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            $display("[ERR] run length expected 30000 seen %0d", cyc);
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [24:0] ea;
        logic [24:0] pa;
        logic lk;
        void'($urandom(77872));
        for (int i = 0; i < 65; i++) otp_m[i] = 8'hff;
        repeat (6) @(posedge MCLK);
        #2;
        ARST_N = 1'b1;
        tick(4);
        chk("flag", `FSR_FLAG_RST, FLAG_STATUS);
        d = {8'h00};
        cmd(`FSR_CMD_OTP_PGM, 24'h0, 3, 0);
        chk("wip", 0, WIP);
        chk("flag", `FSR_FLAG_RST, FLAG_STATUS);
        $display("test otp_no_latch done");
        // Program across the control byte, then read past the end
        repeat (5) d.push_back(8'($urandom) | 8'h01);
        otp_pgm(24'h3e);
        otp_rd(24'h3e, 5);
        for (int k = 0; k < 3; k++) begin
            ea = 25'($urandom_range(63));
            repeat (2) d.push_back(8'($urandom) | 8'h01);
            otp_pgm(ea[23:0]);
            otp_rd(ea[23:0], 3);
        end
        $display("test otp_rw done");
        d = {8'hfe};
        otp_pgm(24'h40);
        d = {8'h00};
        otp_pgm(24'h00);
        pulse_clr();
        otp_rd(24'h00, 1);
        $display("test otp_lock done");
        cmd(`FSR_CMD_SUSPEND, 24'h0, 0, 0);
        chk("halts", 0, {HALT_PGM, HALT_ERS});
        cmd(`FSR_CMD_RESUME, 24'h0, 0, 0);
        chk("wip_flag", 9'h080, {WIP, FLAG_STATUS});
        // Program or erase, picked at random, near its end completes instead of halting
        OP_ADDR = 25'h1ffffff;
        lk = 1'($urandom);
        OP_ERASE = lk;
        OP_RUN = 1'b1;
        OP_NEAR_DONE = 1'b1;
        cmd(`FSR_CMD_SUSPEND, 24'h0, 0, 0);
        chk("near", {1'b0, lk, 3'h0, ~lk, 4'h0}, {FLAG_STATUS, HALT_PGM, HALT_ERS});
        OP_RUN = 1'b0;
        OP_NEAR_DONE = 1'b0;
        tick(4);
        chk("flag", 8'h80, FLAG_STATUS);
        $display("test idle_commands done");
        ea = 25'($urandom);
        lk = 1'($urandom);
        pa = ea ^ 25'h010000;
        OP_ADDR = ea;
        OP_ERASE = 1'b1;
        OP_RUN = 1'b1;
        LOCK_IN = lk;
        cmd(`FSR_CMD_SUSPEND, 24'h0, 0, 0);
        chk("halts", 2'b01, {HALT_PGM, HALT_ERS});
        chk("flag6", 1, FLAG_STATUS[6]);
        OP_RUN = 1'b0;
        LOCK_IN = ~lk;
        tick(2);
        chk("ready", 0, FLAG_STATUS[7]);
        tick(LAT + 6);
        chk("flag", 8'hc0, FLAG_STATUS);
        chk("lock", lk, ERS_LOCK);
        scr(ea ^ 25'h00ff00, 1'b1);
        scr(pa, 1'b0);
        preq(pa, 1'b0);
        preq(ea ^ 25'h000010, 1'b1);
        chk("flag_welclr", 9'h1a0, {FLAG_STATUS, WEL_CLR});
        pulse_clr();
        $display("test erase_suspend done");
        OP_ADDR = pa;
        OP_ERASE = 1'b0;
        OP_RUN = 1'b1;
        cmd(`FSR_CMD_SUSPEND, 24'h0, 0, 0);
        chk("halts", 2'b11, {HALT_PGM, HALT_ERS});
        OP_RUN = 1'b0;
        tick(LAT + 6);
        chk("flag", 8'hc4, FLAG_STATUS);
        scr(pa ^ 25'h000003, 1'b1);
        scr(pa ^ 25'h000100, 1'b0);
        cmd(`FSR_CMD_RESUME, 24'h0, 0, 0);
        chk("halts", 2'b01, {HALT_PGM, HALT_ERS});
        chk("wip_ready", 2'b10, {WIP, FLAG_STATUS[7]});
        run_op(1'b0);
        cmd(`FSR_CMD_RESUME, 24'h0, 0, 0);
        chk("halts", 0, {HALT_PGM, HALT_ERS});
        run_op(1'b1);
        chk("flag", 8'h80, FLAG_STATUS);
        $display("test nested_suspend done");
        // Power loss in mid-run drops a pending erase suspension
        OP_RUN = 1'b1;
        cmd(`FSR_CMD_SUSPEND, 24'h0, 0, 0);
        chk("halts", 2'b01, {HALT_PGM, HALT_ERS});
        OP_RUN = 1'b0;
        ARST_N = 1'b0;
        tick(2);
        ARST_N = 1'b1;
        tick(4);
        chk("flag_halts", 10'h200, {FLAG_STATUS, HALT_PGM, HALT_ERS});
        $display("test power_loss done");
        conclude();
    end
endmodule // flash_suspend_resume_otp_ctrl_test
